/* verilog/hv_prog_port.sv */
/*
 Device side of the high-voltage parallel programming port: entry latch,
 strobed byte loads, command decode, erase, page programming and reads.
 Assumes all pins are synchronous to core_clk and hv_present mirrors
 high voltage on the reset pin.
*/
module hv_prog_port #(
    parameter int WRITE_WAIT_CYC = hv_prog_pkg::NV_WRITE_CYC,
    // Identity values below are arbitrary
    parameter logic [7:0] SIG_BYTE0 = 8'hA5,
    parameter logic [7:0] SIG_BYTE1 = 8'h5A,
    parameter logic [7:0] SIG_BYTE2 = 8'h3C,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // High voltage on reset pin
    input wire logic hv_present,
    // Strobes
    input wire logic load_strobe,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic page_latch_pulse,
    // Selects
    input wire logic strobe_action_bit0,
    input wire logic strobe_action_bit1,
    input wire logic byte_select_low_bit,
    input wire logic byte_select_high_bit,
    // Data bus
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    // Status
    output logic ready_busy_out,
    output logic prog_mode
);
    hv_prog_pkg::op_state_t state_q, state_d;
    logic [hv_prog_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] cmd_q, cmd_d;
    logic [7:0] addr_lo_q, addr_lo_d, addr_hi_q, addr_hi_d, addr_ext_q, addr_ext_d;
    logic [7:0] data_lo_q, data_lo_d, data_hi_q, data_hi_d;
    logic [7:0] fuse_lo_q, fuse_lo_d, fuse_hi_q, fuse_hi_d, fuse_ext_q, fuse_ext_d;
    logic [7:0] lock_q, lock_d;
    logic [7:0] data_out_q, data_out_d;
    logic rdy_q, rdy_d;
    logic load_prev_q, wr_prev_q, pl_prev_q, hv_prev_q;
    logic load_rise, wr_fall, pl_rise, hv_rise, idle, busy_d;
    logic [1:0] act, bs;
    logic [hv_prog_pkg::FLASH_AW-1:0] flash_addr;
    logic [hv_prog_pkg::EE_AW-1:0] ee_addr;
    logic keep_eeprom_on_erase;
    logic fl_we, ee_we;
    logic [hv_prog_pkg::FLASH_AW-1:0] fl_wa;
    logic [hv_prog_pkg::EE_AW-1:0] ee_wa;
    logic [15:0] fl_wd;
    logic [7:0] ee_wd, rd_byte, fl_rd_lo;

    logic [15:0] flash_mem [hv_prog_pkg::FLASH_WORDS];
    logic [7:0] ee_mem [hv_prog_pkg::EE_BYTES];

    page_buf_if pb ();

    page_buffer u_buf (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pb(pb)
    );

    assign load_rise = load_strobe && !load_prev_q;
    assign wr_fall = !write_strobe_n && wr_prev_q;
    assign pl_rise = page_latch_pulse && !pl_prev_q;
    assign hv_rise = hv_present && !hv_prev_q;
    assign act = {strobe_action_bit1, strobe_action_bit0};
    assign bs = {byte_select_high_bit, byte_select_low_bit};
    assign idle = state_q == hv_prog_pkg::ST_IDLE;
    // Page from upper bits, word from low six bits
    assign flash_addr = {addr_hi_q[4:0], addr_lo_q};
    // Page from bits 8..2, byte from bits 1..0
    assign ee_addr = {addr_hi_q[0], addr_lo_q};
    // Fuse bit is active low: zero means programmed, takes effect at once
    assign keep_eeprom_on_erase = !fuse_hi_q[hv_prog_pkg::KEEP_EE_BIT];

    // Read byte selection follows the loaded command
    always_comb begin
        rd_byte = hv_prog_pkg::NO_DATA;
        case (cmd_q)
            hv_prog_pkg::CMD_RD_FLASH: begin
                rd_byte = byte_select_low_bit ? flash_mem[flash_addr][15:8]
                                              : flash_mem[flash_addr][7:0];
            end
            hv_prog_pkg::CMD_RD_EE: rd_byte = ee_mem[ee_addr];
            hv_prog_pkg::CMD_RD_FUSE: begin
                case (bs)
                    hv_prog_pkg::BS_LOW: rd_byte = fuse_lo_q;
                    hv_prog_pkg::BS_HIGH: rd_byte = lock_q;
                    hv_prog_pkg::BS_EXT: rd_byte = fuse_ext_q;
                    default: rd_byte = fuse_hi_q;
                endcase
            end
            hv_prog_pkg::CMD_RD_SIG: begin
                if (byte_select_low_bit) begin
                    rd_byte = CAL_BYTE;
                end else begin
                    case (addr_lo_q[1:0])
                        2'h0: rd_byte = SIG_BYTE0;
                        2'h1: rd_byte = SIG_BYTE1;
                        2'h2: rd_byte = SIG_BYTE2;
                        default: rd_byte = hv_prog_pkg::NO_DATA;
                    endcase
                end
            end
            default: rd_byte = hv_prog_pkg::NO_DATA;
        endcase
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cmd_d = cmd_q;
        addr_lo_d = addr_lo_q;
        addr_hi_d = addr_hi_q;
        addr_ext_d = addr_ext_q;
        data_lo_d = data_lo_q;
        data_hi_d = data_hi_q;
        fuse_lo_d = fuse_lo_q;
        fuse_hi_d = fuse_hi_q;
        fuse_ext_d = fuse_ext_q;
        lock_d = lock_q;
        fl_we = 1'b0;
        fl_wa = flash_addr;
        fl_wd = hv_prog_pkg::ERASED_WORD;
        ee_we = 1'b0;
        ee_wa = ee_addr;
        ee_wd = hv_prog_pkg::ERASED_BYTE;
        pb.clear = 1'b0;
        pb.word_we = 1'b0;
        pb.word_idx = flash_addr[hv_prog_pkg::WORD_IDX_W-1:0];
        pb.word_wd = {data_hi_q, data_lo_q};
        pb.word_ri = cnt_q[hv_prog_pkg::WORD_IDX_W-1:0];
        pb.ee_we = 1'b0;
        pb.ee_idx = addr_lo_q[hv_prog_pkg::EE_IDX_W-1:0];
        pb.ee_wd = data_lo_q;
        pb.ee_ri = cnt_q[hv_prog_pkg::EE_IDX_W-1:0];
        case (state_q)
            hv_prog_pkg::ST_OFF: begin
                // Pattern caught on the cycle high voltage appears
                if (hv_rise && {page_latch_pulse, strobe_action_bit1, strobe_action_bit0,
                    byte_select_low_bit} == hv_prog_pkg::ENTRY_PATTERN) begin
                    state_d = hv_prog_pkg::ST_IDLE;
                end
            end
            hv_prog_pkg::ST_IDLE: begin
                if (wr_fall) begin
                    cnt_d = '0;
                    case (cmd_q)
                        hv_prog_pkg::CMD_CHIP_ERASE: state_d = hv_prog_pkg::ST_ERASE_FLASH;
                        hv_prog_pkg::CMD_WR_FLASH: state_d = hv_prog_pkg::ST_PROG_FLASH;
                        hv_prog_pkg::CMD_WR_EE: state_d = hv_prog_pkg::ST_PROG_EE;
                        hv_prog_pkg::CMD_WR_FUSE: begin
                            // Fuse byte chosen by byte select
                            state_d = hv_prog_pkg::ST_NV_WAIT;
                            case (bs)
                                hv_prog_pkg::BS_LOW: fuse_lo_d = data_lo_q;
                                hv_prog_pkg::BS_HIGH: fuse_hi_d = data_lo_q;
                                hv_prog_pkg::BS_EXT: fuse_ext_d = data_lo_q;
                                default: state_d = hv_prog_pkg::ST_IDLE;
                            endcase
                        end
                        hv_prog_pkg::CMD_WR_LOCK: begin
                            // Lock bits only program to zero; erase alone clears them
                            lock_d = lock_q & data_lo_q;
                            state_d = hv_prog_pkg::ST_NV_WAIT;
                        end
                        default: state_d = hv_prog_pkg::ST_IDLE;
                    endcase
                end else if (load_rise) begin
                    case (act)
                        hv_prog_pkg::ACT_ADDR: begin
                            case (bs)
                                hv_prog_pkg::BS_LOW: addr_lo_d = data_in;
                                hv_prog_pkg::BS_HIGH: addr_hi_d = data_in;
                                hv_prog_pkg::BS_EXT: addr_ext_d = data_in;
                                default: addr_lo_d = addr_lo_q;
                            endcase
                        end
                        hv_prog_pkg::ACT_DATA: begin
                            if (bs == hv_prog_pkg::BS_LOW) begin
                                data_lo_d = data_in;
                            end else if (bs == hv_prog_pkg::BS_HIGH) begin
                                data_hi_d = data_in;
                            end
                        end
                        hv_prog_pkg::ACT_CMD: begin
                            cmd_d = data_in;
                            // No-operation drops any half-filled page
                            pb.clear = data_in == hv_prog_pkg::CMD_NOP;
                        end
                        default: cmd_d = cmd_q;
                    endcase
                end else if (pl_rise) begin
                    // Page latch writes the held bytes into the buffer
                    pb.word_we = cmd_q == hv_prog_pkg::CMD_WR_FLASH;
                    pb.ee_we = cmd_q == hv_prog_pkg::CMD_WR_EE;
                end
            end
            hv_prog_pkg::ST_ERASE_FLASH: begin
                // One word per cycle; erased cells read FF
                fl_we = 1'b1;
                fl_wa = cnt_q;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == hv_prog_pkg::CNT_W'(hv_prog_pkg::FLASH_WORDS - 1)) begin
                    cnt_d = '0;
                    state_d = keep_eeprom_on_erase ? hv_prog_pkg::ST_ERASE_LOCK
                                                   : hv_prog_pkg::ST_ERASE_EE;
                end
            end
            hv_prog_pkg::ST_ERASE_EE: begin
                ee_we = 1'b1;
                ee_wa = cnt_q[hv_prog_pkg::EE_AW-1:0];
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == hv_prog_pkg::CNT_W'(hv_prog_pkg::EE_BYTES - 1)) begin
                    cnt_d = '0;
                    state_d = hv_prog_pkg::ST_ERASE_LOCK;
                end
            end
            hv_prog_pkg::ST_ERASE_LOCK: begin
                // Reached only once the flash sweep has finished
                lock_d = hv_prog_pkg::LOCK_RST;
                state_d = hv_prog_pkg::ST_NV_WAIT;
            end
            hv_prog_pkg::ST_PROG_FLASH: begin
                // Whole page copied from the buffer
                fl_we = 1'b1;
                fl_wa = {flash_addr[hv_prog_pkg::FLASH_AW-1:hv_prog_pkg::WORD_IDX_W],
                         cnt_q[hv_prog_pkg::WORD_IDX_W-1:0]};
                fl_wd = pb.word_rd;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == hv_prog_pkg::CNT_W'(hv_prog_pkg::PAGE_WORDS - 1)) begin
                    cnt_d = '0;
                    pb.clear = 1'b1;
                    state_d = hv_prog_pkg::ST_NV_WAIT;
                end
            end
            hv_prog_pkg::ST_PROG_EE: begin
                ee_we = 1'b1;
                ee_wa = {ee_addr[hv_prog_pkg::EE_AW-1:hv_prog_pkg::EE_IDX_W],
                         cnt_q[hv_prog_pkg::EE_IDX_W-1:0]};
                ee_wd = pb.ee_rd;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == hv_prog_pkg::CNT_W'(hv_prog_pkg::EE_PAGE_BYTES - 1)) begin
                    cnt_d = '0;
                    pb.clear = 1'b1;
                    state_d = hv_prog_pkg::ST_NV_WAIT;
                end
            end
            hv_prog_pkg::ST_NV_WAIT: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == hv_prog_pkg::CNT_W'(WRITE_WAIT_CYC - 1)) begin
                    cnt_d = '0;
                    state_d = hv_prog_pkg::ST_IDLE;
                end
            end
            default: state_d = hv_prog_pkg::ST_OFF;
        endcase
        // Losing high voltage ends programming mode at once
        if (!hv_present) begin
            state_d = hv_prog_pkg::ST_OFF;
            cnt_d = '0;
        end
        busy_d = state_d != hv_prog_pkg::ST_IDLE && state_d != hv_prog_pkg::ST_OFF;
        rdy_d = !busy_d;
        data_out_d = rd_byte;
    end

    always_ff @(posedge core_clk) begin
        if (fl_we) begin
            flash_mem[fl_wa] <= fl_wd;
        end
        if (ee_we) begin
            ee_mem[ee_wa] <= ee_wd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= hv_prog_pkg::ST_OFF;
            cnt_q <= '0;
            cmd_q <= hv_prog_pkg::CMD_NOP;
            addr_lo_q <= '0;
            addr_hi_q <= '0;
            addr_ext_q <= '0;
            data_lo_q <= '0;
            data_hi_q <= '0;
            fuse_lo_q <= hv_prog_pkg::FUSE_LO_RST;
            fuse_hi_q <= hv_prog_pkg::FUSE_HI_RST;
            fuse_ext_q <= hv_prog_pkg::FUSE_EXT_RST;
            lock_q <= hv_prog_pkg::LOCK_RST;
            data_out_q <= '0;
            rdy_q <= 1'b1;
            load_prev_q <= 1'b0;
            wr_prev_q <= 1'b1;
            pl_prev_q <= 1'b0;
            hv_prev_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
            addr_lo_q <= addr_lo_d;
            addr_hi_q <= addr_hi_d;
            addr_ext_q <= addr_ext_d;
            data_lo_q <= data_lo_d;
            data_hi_q <= data_hi_d;
            fuse_lo_q <= fuse_lo_d;
            fuse_hi_q <= fuse_hi_d;
            fuse_ext_q <= fuse_ext_d;
            lock_q <= lock_d;
            data_out_q <= data_out_d;
            rdy_q <= rdy_d;
            load_prev_q <= load_strobe;
            wr_prev_q <= write_strobe_n;
            pl_prev_q <= page_latch_pulse;
            hv_prev_q <= hv_present;
        end
    end

    assign data_out = data_out_q;
    // Bus stays released outside programming mode
    assign data_oe_n = output_enable_n || state_q == hv_prog_pkg::ST_OFF;
    assign ready_busy_out = rdy_q;
    assign prog_mode = state_q != hv_prog_pkg::ST_OFF;
    assign fl_rd_lo = flash_mem[flash_addr][7:0];

    erase_busy_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (idle && hv_present && wr_fall && cmd_q == hv_prog_pkg::CMD_CHIP_ERASE)
        |=> !ready_busy_out [*8])
        else $error("erase did not hold ready/busy low");
    erase_order_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == hv_prog_pkg::ST_ERASE_LOCK) |->
        ($past(state_q) == hv_prog_pkg::ST_ERASE_FLASH
         || $past(state_q) == hv_prog_pkg::ST_ERASE_EE))
        else $error("lock bits cleared before flash erase ended");
    busy_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!ready_busy_out && hv_present) |=> $stable(cmd_q) && $stable(addr_lo_q))
        else $error("load accepted while busy");
    flash_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!data_oe_n && cmd_q == hv_prog_pkg::CMD_RD_FLASH && !byte_select_low_bit)
        |=> data_out == $past(fl_rd_lo))
        else $error("flash low byte not presented");
    cmd_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (idle && hv_present && !wr_fall && load_rise && act == hv_prog_pkg::ACT_CMD)
        |=> cmd_q == $past(data_in))
        else $error("command byte not loaded");
    addr_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (idle && hv_present && !wr_fall && load_rise && act == hv_prog_pkg::ACT_ADDR
         && bs == hv_prog_pkg::BS_HIGH) |=> addr_hi_q == $past(data_in) && $stable(addr_lo_q))
        else $error("high address byte not loaded");
    mode_exit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !hv_present |=> !prog_mode && ready_busy_out)
        else $error("programming mode kept without high voltage");
    page_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($rose(state_q == hv_prog_pkg::ST_PROG_FLASH) && hv_present)
        |-> ##63 (state_q == hv_prog_pkg::ST_PROG_FLASH || !prog_mode)
        ##1 (state_q == hv_prog_pkg::ST_NV_WAIT || !prog_mode))
        else $error("page program length wrong");
endmodule

/* verilog/hv_prog_pkg.sv */
/*
 Shared constants for the high-voltage parallel programming port:
 memory geometry, pin codings, command bytes, reset values, timing.
 Assumes a single 125 MHz core clock.
*/
package hv_prog_pkg;
    // Memory geometry
    localparam int FLASH_WORDS = 8192;
    localparam int FLASH_AW = 13;
    localparam int PAGE_WORDS = 64;
    localparam int WORD_IDX_W = 6;
    localparam int EE_BYTES = 512;
    localparam int EE_AW = 9;
    localparam int EE_PAGE_BYTES = 4;
    localparam int EE_IDX_W = 2;
    localparam int CNT_W = 13;

    // Load strobe action codes {action_bit1, action_bit0}
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;

    // Byte select codes {high_bit, low_bit}
    localparam logic [1:0] BS_LOW = 2'h0;
    localparam logic [1:0] BS_HIGH = 2'h1;
    localparam logic [1:0] BS_EXT = 2'h2;
    localparam logic [1:0] BS_FUSE_HI = 2'h3;

    // Command bytes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EE = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EE = 8'h03;

    // Entry pattern {page latch, action1, action0, byte select low}
    localparam logic [3:0] ENTRY_PATTERN = 4'h0;

    // Erased contents and reset values
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0] FUSE_LO_RST = 8'h62;
    localparam logic [7:0] FUSE_HI_RST = 8'h99;
    localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam int KEEP_EE_BIT = 3;
    localparam logic [7:0] NO_DATA = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int NV_WRITE_NS = 2000;
    localparam int NV_WRITE_CYC = NV_WRITE_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_IDLE,
        ST_ERASE_FLASH,
        ST_ERASE_EE,
        ST_ERASE_LOCK,
        ST_PROG_FLASH,
        ST_PROG_EE,
        ST_NV_WAIT
    } op_state_t;
endpackage

/* verilog/page_buf_if.sv */
/*
 Interface between the programming control and its page buffer.
 Assumes both ends share the core clock.
*/
interface page_buf_if;
    logic clear;
    logic word_we;
    logic [hv_prog_pkg::WORD_IDX_W-1:0] word_idx;
    logic [15:0] word_wd;
    logic [hv_prog_pkg::WORD_IDX_W-1:0] word_ri;
    logic [15:0] word_rd;
    logic ee_we;
    logic [hv_prog_pkg::EE_IDX_W-1:0] ee_idx;
    logic [7:0] ee_wd;
    logic [hv_prog_pkg::EE_IDX_W-1:0] ee_ri;
    logic [7:0] ee_rd;

    modport owner (
        output clear, word_we, word_idx, word_wd, word_ri, ee_we, ee_idx, ee_wd, ee_ri,
        input word_rd, ee_rd
    );
    modport store (
        input clear, word_we, word_idx, word_wd, word_ri, ee_we, ee_idx, ee_wd, ee_ri,
        output word_rd, ee_rd
    );
endinterface

/* verilog/page_buffer.sv */
/*
 Page buffer for one flash page of words and one EEPROM page of bytes.
 Assumes the owner clears it after each page program.
*/
module page_buffer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Owner side
    page_buf_if.store pb
);
    logic [15:0] word_q [hv_prog_pkg::PAGE_WORDS];
    logic [7:0] byte_q [hv_prog_pkg::EE_PAGE_BYTES];

    // Unloaded entries stay erased so a partial page writes erased words into them
    genvar i;
    generate
        for (i = 0; i < hv_prog_pkg::PAGE_WORDS; i++) begin : g_word
            always_ff @(posedge core_clk) begin
                if (sys_rst || pb.clear) begin
                    word_q[i] <= hv_prog_pkg::ERASED_WORD;
                end else if (pb.word_we && pb.word_idx == i) begin
                    word_q[i] <= pb.word_wd;
                end
            end
        end
        for (i = 0; i < hv_prog_pkg::EE_PAGE_BYTES; i++) begin : g_byte
            always_ff @(posedge core_clk) begin
                if (sys_rst || pb.clear) begin
                    byte_q[i] <= hv_prog_pkg::ERASED_BYTE;
                end else if (pb.ee_we && pb.ee_idx == i) begin
                    byte_q[i] <= pb.ee_wd;
                end
            end
        end
    endgenerate

    assign pb.word_rd = word_q[pb.word_ri];
    assign pb.ee_rd = byte_q[pb.ee_ri];
endmodule

/* testbench/hv_programmer.sv */
/*
 Programmer model for the parallel programming pins; the bench calls its tasks.
 Assumes the device's core clock and that each call starts just after an edge.
*/
module hv_programmer (
    // Clock and device outputs
    input wire logic core_clk,
    input wire logic ready_busy_out,
    input wire logic data_oe_n,
    input wire logic [7:0] data_out,
    // Pins toward the device
    output logic hv_present, load_strobe, write_strobe_n, output_enable_n, page_latch_pulse,
    output logic strobe_action_bit0, strobe_action_bit1, byte_select_low_bit, byte_select_high_bit,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] act;
    logic [1:0] bs;
    assign {strobe_action_bit1, strobe_action_bit0} = act;
    assign {byte_select_high_bit, byte_select_low_bit} = bs;
    // Entry pattern pins start at zero
    initial begin
        {hv_present, load_strobe, page_latch_pulse, act, bs, data_in} = '0;
        {write_strobe_n, output_enable_n} = 2'h3;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Pattern held well past the rise, first command after a settle
    task automatic enter();
        cyc(2);
        hv_present <= 1'b1;
        cyc(6);
    endtask
    task automatic leave();
        hv_present <= 1'b0;
        cyc(2);
    endtask
    // Strobe two cycles high and two low, so no edge is missed
    task automatic load(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
        {act, bs, data_in} <= {a, b, d};
        cyc(1);
        load_strobe <= 1'b1;
        cyc(2);
        {load_strobe, act} <= 3'h3;
        cyc(2);
    endtask
    // Both data bytes go into the buffer on one pulse
    task automatic latch();
        page_latch_pulse <= 1'b1;
        cyc(2);
        page_latch_pulse <= 1'b0;
        cyc(2);
    endtask
    // Nothing new until ready returns; a hang ends after the bound
    task automatic write(output logic rb, output int n);
        write_strobe_n <= 1'b0;
        cyc(2);
        write_strobe_n <= 1'b1;
        #1 rb = ready_busy_out;
        for (n = 0; n < 20000 && ready_busy_out !== 1'b1; n++) begin
            cyc(1);
            #1;
        end
    endtask
    // Own drive flips while the device owns the bus
    task automatic read(input logic [1:0] b, output logic [7:0] q);
        {bs, output_enable_n, data_in} <= {b, 1'b0, ~data_in};
        cyc(3);
        #1 q = data_oe_n ? 8'hZZ : data_out;
        output_enable_n <= 1'b1;
        cyc(1);
    endtask
endmodule

/* testbench/tb_top.sv */
/*
 Self-checking bench for the programming port: entry, reads, erase, page writes, exit.
 Assumes the programmer model and a 125 MHz clock.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Identity values are arbitrary
    localparam logic [7:0] SG [4] = '{8'h21, 8'h43, 8'h65, 8'h00};
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hv_present, load_strobe, write_strobe_n, output_enable_n, page_latch_pulse;
    logic strobe_action_bit0, strobe_action_bit1, byte_select_low_bit, byte_select_high_bit;
    logic [7:0] data_in, data_out;
    logic data_oe_n, ready_busy_out, prog_mode;
    int err_total = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    hv_prog_port #(.WRITE_WAIT_CYC(2), .SIG_BYTE0(SG[0]), .SIG_BYTE1(SG[1]), .SIG_BYTE2(SG[2]),
        .CAL_BYTE(8'h87)) uut (.core_clk, .sys_rst, .hv_present, .load_strobe, .write_strobe_n,
        .output_enable_n, .page_latch_pulse, .strobe_action_bit0, .strobe_action_bit1,
        .byte_select_low_bit, .byte_select_high_bit, .data_in, .data_out, .data_oe_n,
        .ready_busy_out, .prog_mode);
    hv_programmer p (.core_clk, .ready_busy_out, .data_oe_n, .data_out, .hv_present,
        .load_strobe, .write_strobe_n, .output_enable_n, .page_latch_pulse, .strobe_action_bit0,
        .strobe_action_bit1, .byte_select_low_bit, .byte_select_high_bit, .data_in);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Fuse and lock byte expected for a byte select code
    function automatic logic [7:0] fuse_exp(input logic [1:0] b, input logic [7:0] lo, lk);
        return b == 2'h0 ? lo : b == 2'h1 ? lk : b == 2'h2 ? hv_prog_pkg::FUSE_EXT_RST
            : hv_prog_pkg::FUSE_HI_RST;
    endfunction
    task automatic fuse_sweep(input logic [7:0] lo, lk);
        logic [7:0] v;
        p.load(2'h2, 2'h0, 8'h04);
        for (int i = 0; i < 4; i++) begin
            p.read(i[1:0], v);
            check("fuse byte", 16'(fuse_exp(i[1:0], lo, lk)), 16'(v));
        end
    endtask
    always @(posedge core_clk) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        logic rb;
        int n;
        logic [7:0] q, q2, fz;
        logic [6:0] pg;
        logic [8:0] ea;
        logic [5:0] wi [4];
        logic [15:0] wd [4];
        void'($urandom(32'h2d81ff66));
        repeat (12) @(posedge core_clk);
        check("ready in reset", 16'h1, 16'(ready_busy_out));
        sys_rst <= 1'b0;
        p.enter();
        check("mode entry", 16'h1, 16'(prog_mode));
        fuse_sweep(hv_prog_pkg::FUSE_LO_RST, hv_prog_pkg::LOCK_RST);
        // Command loaded once, then only the address changes
        p.load(2'h2, 2'h0, 8'h08);
        for (int i = 0; i < 4; i++) begin
            p.load(2'h0, 2'h0, 8'(i));
            p.read(2'h0, q);
            check("signature", 16'(SG[i]), 16'(q));
        end
        p.read(2'h1, q);
        check("calibration", 16'h87, 16'(q));
        // Low fuse gets a random byte, locks only program towards zero
        fz = 8'($urandom);
        p.load(2'h2, 2'h0, 8'h40);
        p.load(2'h1, 2'h0, fz);
        p.write(rb, n);
        check("fuse busy", 16'h0, 16'(rb));
        p.load(2'h2, 2'h0, 8'h20);
        p.load(2'h1, 2'h0, 8'hFC);
        p.write(rb, n);
        fuse_sweep(fz, 8'hFC);
        $display("entry and identity test done");
        p.load(2'h2, 2'h0, 8'h80);
        p.write(rb, n);
        check("erase busy", 16'h0, 16'(rb));
        check("erase length", 16'h1, 16'(n > 8600));
        fuse_sweep(fz, hv_prog_pkg::LOCK_RST);
        pg = 7'($urandom);
        p.load(2'h2, 2'h0, 8'h10);
        p.load(2'h0, 2'h1, {3'h0, pg[6:2]});
        for (int k = 0; k < 4; k++) begin
            wi[k] = 6'(k * 16 + $urandom % 15);
            wd[k] = 16'($urandom);
            p.load(2'h0, 2'h0, {pg[1:0], wi[k]});
            p.load(2'h1, 2'h0, wd[k][7:0]);
            p.load(2'h1, 2'h1, wd[k][15:8]);
            p.latch();
        end
        p.write(rb, n);
        check("page busy", 16'h0, 16'(rb));
        check("page length", 16'h1, 16'(n >= 64 && n < 20000));
        // Word 15 of the page is never latched, so it stays erased
        p.load(2'h2, 2'h0, 8'h02);
        for (int k = 0; k < 5; k++) begin
            p.load(2'h0, 2'h0, {pg[1:0], k < 4 ? wi[k] : 6'h0F});
            p.read(2'h0, q);
            p.read(2'h1, q2);
            check("flash word", k < 4 ? wd[k] : 16'hFFFF, {q2, q});
        end
        $display("erase and flash test done");
        ea = 9'($urandom);
        q = 8'($urandom);
        p.load(2'h2, 2'h0, 8'h11);
        p.load(2'h0, 2'h1, {7'h0, ea[8]});
        p.load(2'h0, 2'h0, ea[7:0]);
        p.load(2'h1, 2'h0, q);
        p.latch();
        p.write(rb, n);
        p.load(2'h2, 2'h0, 8'h03);
        p.read(2'h0, q2);
        check("eeprom byte", 16'(q), 16'(q2));
        p.load(2'h0, 2'h0, ea[7:0] ^ 8'h01);
        p.read(2'h0, q2);
        check("eeprom erased", 16'hFF, 16'(q2));
        p.leave();
        check("mode exit", 16'h0, 16'(prog_mode));
        $display("eeprom and exit test done");
        summarize();
    end
endmodule
